// [shared/tc_status_pkg.sv]
// constants and carrier types for the timer channel status and irq block
// assumes a 32-bit classic wishbone slave on a single 125 MHz clock
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package tc_status_pkg;

    // -----------------------------------------------------------------
    // register offsets (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS     = 8'h00;
    localparam logic [7:0] OFS_IRQ_SET    = 8'h04;
    localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h0C;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int BIT_OVERFLOW   = 0;
    localparam int BIT_OVERRUN    = 1;
    localparam int BIT_CMP_A      = 2;
    localparam int BIT_CMP_B      = 3;
    localparam int BIT_CMP_C      = 4;
    localparam int BIT_LOAD_A     = 5;
    localparam int BIT_LOAD_B     = 6;
    localparam int BIT_EXT_TRIG   = 7;
    localparam int BIT_CLOCK_ON   = 16;
    localparam int BIT_LINE_A     = 17;
    localparam int BIT_LINE_B     = 18;
    localparam int NUM_SOURCES    = 8;

    localparam logic [7:0]  FLAGS_RESET = 8'h00;
    localparam logic [7:0]  MASK_RESET  = 8'h00;
    localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

    // events from the counter datapath, one-cycle pulses
    typedef struct packed {
        logic ext_trigger;
        logic load_b;
        logic load_a;
        logic cmp_c;
        logic cmp_b;
        logic cmp_a;
        logic overflow;
    } tc_events_t;

    // register reads that count as consuming a captured value
    typedef struct packed {
        logic reg_b_read;
        logic reg_a_read;
    } capture_reads_t;

    // pin side levels and driven levels of the two timer lines
    typedef struct packed {
        logic pin_b;
        logic pin_a;
        logic drive_b;
        logic drive_a;
    } line_levels_t;

endpackage : tc_status_pkg

// [rtl/tc_overrun_track.sv]
// tracks pending captured values of registers a and b for overrun
// assumes load and read pulses are on clk_i and one cycle wide
module tc_overrun_track
    import tc_status_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           capture_mode_i,
    input  wire logic           load_a_i,
    input  wire logic           load_b_i,
    input  wire capture_reads_t reads_i,
    output logic                overrun_o
);

    logic pend_a_q;
    logic pend_b_q;
    logic pend_a_d;
    logic pend_b_d;
    wire  over_a = load_a_i & pend_a_q & ~reads_i.reg_a_read;
    wire  over_b = load_b_i & pend_b_q & ~reads_i.reg_b_read;

    // a load leaves the value pending; a read without a load consumes it
    assign pend_a_d = load_a_i | (pend_a_q & ~reads_i.reg_a_read);
    assign pend_b_d = load_b_i | (pend_b_q & ~reads_i.reg_b_read);
    assign overrun_o = capture_mode_i & (over_a | over_b);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_a_q <= 1'b0;
            pend_b_q <= 1'b0;
        end else begin
            pend_a_q <= pend_a_d;
            pend_b_q <= pend_b_d;
        end
    end

endmodule : tc_overrun_track

// [rtl/tc_status_regs.sv]
// status flags, interrupt mask and wishbone slave of one timer channel
// assumes events come from the counter datapath on clk_i; pins are async
module tc_status_regs
    import tc_status_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    // wishbone classic slave
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire logic [7:0]     wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic [31:0]    wb_dat_i,
    output logic      [31:0]    wb_dat_o,
    output logic                wb_ack_o,
    // channel side
    input  wire logic           waveform_mode_i,
    input  wire logic           clock_enabled_i,
    input  wire tc_events_t     events_i,
    input  wire capture_reads_t reads_i,
    input  wire line_levels_t   lines_i,
    output logic                irq_o
);

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_q <= 2'b00;
            pin_sync_q <= 2'b00;
        end else begin
            pin_meta_q <= {lines_i.pin_b, lines_i.pin_a};
            pin_sync_q <= pin_meta_q;
        end
    end

    // -----------------------------------------------------------------
    // bus decode
    // -----------------------------------------------------------------
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [7:0]  flags_q;
    logic [7:0]  flags_d;
    logic [7:0]  mask_q;
    logic [7:0]  mask_d;
    logic        irq_q;
    logic        overrun_evt;

    wire req_new    = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr_req     = req_new & wb_we_i;
    wire rd_req     = req_new & ~wb_we_i;
    wire lane0      = wb_sel_i[0];
    wire hit_status = (wb_adr_i == OFS_STATUS);
    wire hit_set    = (wb_adr_i == OFS_IRQ_SET);
    wire hit_clear  = (wb_adr_i == OFS_IRQ_CLEAR);
    wire hit_mask   = (wb_adr_i == OFS_IRQ_MASK);
    wire status_rd  = rd_req & hit_status;
    wire capture    = ~waveform_mode_i;

    wire [7:0] set_bits = (wr_req & hit_set & lane0) ? wb_dat_i[7:0]
                                                     : 8'h00;
    wire [7:0] clr_bits = (wr_req & hit_clear & lane0) ? wb_dat_i[7:0]
                                                       : 8'h00;

    // -----------------------------------------------------------------
    // event flags
    // -----------------------------------------------------------------
    tc_overrun_track u_overrun (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .capture_mode_i (capture),
        .load_a_i       (events_i.load_a),
        .load_b_i       (events_i.load_b),
        .reads_i        (reads_i),
        .overrun_o      (overrun_evt)
    );

    wire [7:0] new_events;
    assign new_events[BIT_OVERFLOW] = events_i.overflow;
    assign new_events[BIT_OVERRUN]  = overrun_evt;
    assign new_events[BIT_CMP_A]    = events_i.cmp_a & waveform_mode_i;
    assign new_events[BIT_CMP_B]    = events_i.cmp_b & waveform_mode_i;
    assign new_events[BIT_CMP_C]    = events_i.cmp_c;
    assign new_events[BIT_LOAD_A]   = events_i.load_a & capture;
    assign new_events[BIT_LOAD_B]   = events_i.load_b & capture;
    assign new_events[BIT_EXT_TRIG] = events_i.ext_trigger;

    // read clears, but an event in the same cycle stays set
    assign flags_d = new_events | (status_rd ? 8'h00 : flags_q);

    // set wins over clear when both are written in one cycle
    assign mask_d = set_bits | (mask_q & ~clr_bits);

    // -----------------------------------------------------------------
    // read data
    // -----------------------------------------------------------------
    // capture-only flags read 0 in waveform mode and vice versa
    wire [7:0] mode_gate = waveform_mode_i
        ? ~(8'h01 << BIT_OVERRUN | 8'h01 << BIT_LOAD_A | 8'h01 << BIT_LOAD_B)
        : ~(8'h01 << BIT_CMP_A | 8'h01 << BIT_CMP_B);
    wire [7:0] flags_vis = flags_q & mode_gate;

    wire line_a = waveform_mode_i ? lines_i.drive_a : pin_sync_q[0];
    wire line_b = waveform_mode_i ? lines_i.drive_b : pin_sync_q[1];

    logic [31:0] status_word;
    always_comb begin
        status_word               = READ_ZERO;
        status_word[7:0]          = flags_vis;
        status_word[BIT_CLOCK_ON] = clock_enabled_i;
        status_word[BIT_LINE_A]   = line_a;
        status_word[BIT_LINE_B]   = line_b;
    end

    wire [31:0] mask_word = {24'h000000, mask_q};
    wire [31:0] rdata_d   = !rd_req    ? READ_ZERO :
                            hit_status ? status_word :
                            hit_mask   ? mask_word : READ_ZERO;

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= READ_ZERO;
            flags_q <= FLAGS_RESET;
            mask_q  <= MASK_RESET;
            irq_q   <= 1'b0;
        end else begin
            ack_q   <= req_new;
            rdata_q <= rdata_d;
            flags_q <= flags_d;
            mask_q  <= mask_d;
            irq_q   <= |(flags_d & mode_gate & mask_d);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign irq_o    = irq_q;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_ack_one_cycle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle answer");

    a_ack_no_request: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(wb_cyc_i && wb_stb_i)
        |=> !wb_ack_o)
        else $error("ack without a request");

    a_rdata_zero_idle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rd_req
        |=> wb_dat_o == READ_ZERO)
        else $error("read data not zero outside a read answer");

    a_status_hi_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        status_rd
        |=> wb_dat_o[31:19] == 13'h0000 && wb_dat_o[15:8] == 8'h00)
        else $error("unused status bits not zero");

    // -----------------------------------------------------------------
    // flag checks
    // -----------------------------------------------------------------
    a_trig_sets_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        events_i.ext_trigger
        |=> flags_q[BIT_EXT_TRIG])
        else $error("external trigger flag not set");

    a_ovf_sets_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        events_i.overflow
        |=> flags_q[BIT_OVERFLOW])
        else $error("overflow flag not set");

    a_load_b_capture: assert property (
        @(posedge clk_i) disable iff (rst_i)
        capture && events_i.load_b
        |=> flags_q[BIT_LOAD_B])
        else $error("load b flag not set in capture mode");

    a_load_b_hidden: assert property (
        @(posedge clk_i) disable iff (rst_i)
        status_rd && waveform_mode_i
        |=> !wb_dat_o[BIT_LOAD_B])
        else $error("load b flag visible in waveform mode");

    a_flags_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !status_rd
        |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("flag lost without a status read");

    a_read_clears_flags: assert property (
        @(posedge clk_i) disable iff (rst_i)
        status_rd && new_events == 8'h00
        |=> flags_q == 8'h00)
        else $error("status read did not clear flags");

    a_overrun_capture: assert property (
        @(posedge clk_i) disable iff (rst_i)
        overrun_evt
        |=> flags_q[BIT_OVERRUN])
        else $error("overrun flag not set");

    // -----------------------------------------------------------------
    // mask checks
    // -----------------------------------------------------------------
    a_enable_write_sets: assert property (
        @(posedge clk_i) disable iff (rst_i)
        set_bits != 8'h00
        |=> (mask_q & $past(set_bits)) == $past(set_bits))
        else $error("enable write did not enable");

    a_disable_write_clr: assert property (
        @(posedge clk_i) disable iff (rst_i)
        set_bits == 8'h00 && clr_bits != 8'h00
        |=> (mask_q & $past(clr_bits)) == 8'h00)
        else $error("disable write did not disable");

    a_mask_stable_idle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        set_bits == 8'h00 && clr_bits == 8'h00
        |=> $stable(mask_q))
        else $error("mask changed without a write");

    a_mask_read_word: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_req && hit_mask
        |=> wb_dat_o == {24'h000000, $past(mask_q)})
        else $error("mask read does not match enabled sources");

    a_cmp_masks: assert property (
        @(posedge clk_i) disable iff (rst_i)
        set_bits[BIT_CMP_C:BIT_OVERRUN] != 4'h0
        |=> (mask_q[BIT_CMP_C:BIT_OVERRUN]
             | ~$past(set_bits[BIT_CMP_C:BIT_OVERRUN])) == 4'hF)
        else $error("overrun or compare enable lost");

    a_load_masks: assert property (
        @(posedge clk_i) disable iff (rst_i)
        set_bits[BIT_LOAD_B:BIT_LOAD_A] != 2'h0
        |=> (mask_q[BIT_LOAD_B:BIT_LOAD_A]
             | ~$past(set_bits[BIT_LOAD_B:BIT_LOAD_A])) == 2'h3)
        else $error("load enable lost");

    // -----------------------------------------------------------------
    // mirror and irq checks
    // -----------------------------------------------------------------
    a_clock_status_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        status_rd
        |=> wb_dat_o[BIT_CLOCK_ON] == $past(clock_enabled_i))
        else $error("clock status bit wrong");

    a_line_a_wave: assert property (
        @(posedge clk_i) disable iff (rst_i)
        status_rd && waveform_mode_i
        |=> wb_dat_o[BIT_LINE_A] == $past(lines_i.drive_a))
        else $error("line a mirror wrong in waveform mode");

    a_line_a_capture: assert property (
        @(posedge clk_i) disable iff (rst_i)
        status_rd && capture
        |=> wb_dat_o[BIT_LINE_A] == $past(pin_sync_q[0]))
        else $error("line a mirror wrong in capture mode");

    a_line_b_wave: assert property (
        @(posedge clk_i) disable iff (rst_i)
        status_rd && waveform_mode_i
        |=> wb_dat_o[BIT_LINE_B] == $past(lines_i.drive_b))
        else $error("line b mirror wrong in waveform mode");

    a_line_b_capture: assert property (
        @(posedge clk_i) disable iff (rst_i)
        status_rd && capture
        |=> wb_dat_o[BIT_LINE_B] == $past(pin_sync_q[1]))
        else $error("line b mirror wrong in capture mode");

    a_irq_follows_flags: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == |(flags_q & mode_gate & mask_q) || !$stable(mode_gate))
        else $error("irq does not follow enabled flags");

    a_irq_set_event: assert property (
        @(posedge clk_i) disable iff (rst_i)
        events_i.ext_trigger && mask_d[BIT_EXT_TRIG]
        |=> irq_o)
        else $error("enabled trigger did not raise irq");

    a_irq_no_mask: assert property (
        @(posedge clk_i) disable iff (rst_i)
        mask_d == 8'h00
        |=> !irq_o)
        else $error("irq raised with all sources disabled");

endmodule : tc_status_regs

// [tb/tc_status_regs_tb_top.sv]
// self-checking bench for the timer channel status and irq register block
// assumes the dut answers classic wishbone and samples events on clk_i
module tc_status_regs_tb_top
    import tc_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clk_i;
    logic           rst_i;
    logic           wb_cyc_i;
    logic           wb_stb_i;
    logic           wb_we_i;
    logic [7:0]     wb_adr_i;
    logic [3:0]     wb_sel_i;
    logic [31:0]    wb_dat_i;
    logic [31:0]    wb_dat_o;
    logic           wb_ack_o;
    logic           waveform_mode_i;
    logic           clock_enabled_i;
    tc_events_t     events_i;
    capture_reads_t reads_i;
    line_levels_t   lines_i;
    logic           irq_o;
    int             n_mismatch;
    int             checks;

    tc_status_regs dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .waveform_mode_i(waveform_mode_i),
        .clock_enabled_i(clock_enabled_i), .events_i(events_i),
        .reads_i(reads_i), .lines_i(lines_i), .irq_o(irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ---------------------------------------------------------------
    // bus, stimulus and compare tasks
    // ---------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic xfer(input logic we, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        check("ack latency", 32'(n), 32'h0000_0002);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        check(nm, q, exp);
    endtask : rd

    task automatic ev(input logic [6:0] e);
        @(posedge clk_i);
        events_i <= tc_events_t'(e);
        @(posedge clk_i);
        events_i <= tc_events_t'(7'h00);
    endtask : ev

    task automatic cap_rd(input logic [1:0] r);
        @(posedge clk_i);
        reads_i <= capture_reads_t'(r);
        @(posedge clk_i);
        reads_i <= capture_reads_t'(2'h0);
    endtask : cap_rd

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk_i);
        check("irq", 32'(irq_o), 32'(exp));
    endtask : irq_chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        $display("Error watchdog expected finish seen hang");
        wrap_up();
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        checks = 0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0000_0000;
        waveform_mode_i = 1'b0;
        clock_enabled_i = 1'b0;
        events_i = tc_events_t'(7'h00);
        reads_i = capture_reads_t'(2'h0);
        lines_i = line_levels_t'(4'h0);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("status reset", OFS_STATUS, 32'h0000_0000);
        rd("mask reset", OFS_IRQ_MASK, 32'h0000_0000);
        rd("unmapped", 8'h10, 32'h0000_0000);
        check("irq reset", 32'(irq_o), 32'h0);
        $display("test reset done");

        for (int i = 0; i < NUM_SOURCES; i++) begin
            wr(OFS_IRQ_SET, 32'h1 << i);
            rd("mask one", OFS_IRQ_MASK, 32'h1 << i);
            wr(OFS_IRQ_CLEAR, 32'h1 << i);
            rd("mask none", OFS_IRQ_MASK, 32'h0);
        end
        wr(OFS_IRQ_SET, 32'h0000_00A5);
        wr(OFS_IRQ_SET, 32'h0000_0000);
        rd("mask set zero", OFS_IRQ_MASK, 32'h0000_00A5);
        wr(OFS_IRQ_CLEAR, 32'h0000_0021);
        wr(OFS_IRQ_CLEAR, 32'h0000_0000);
        wr(OFS_IRQ_MASK, 32'h0000_00FF);
        rd("mask clear", OFS_IRQ_MASK, 32'h0000_0084);
        rd("set reads zero", OFS_IRQ_SET, 32'h0000_0000);
        wr(OFS_IRQ_CLEAR, 32'h0000_00FF);
        $display("test mask done");

        ev(7'h61);
        rd("capture flags", OFS_STATUS, 32'h0000_00C1);
        rd("flags cleared", OFS_STATUS, 32'h0000_0000);
        ev(7'h10);
        ev(7'h10);
        rd("overrun a", OFS_STATUS, 32'h0000_0022);
        ev(7'h20);
        rd("overrun b", OFS_STATUS, 32'h0000_0042);
        cap_rd(2'h3);
        ev(7'h30);
        cap_rd(2'h3);
        ev(7'h30);
        rd("no overrun", OFS_STATUS, 32'h0000_0060);
        $display("test flags done");

        wr(OFS_IRQ_SET, 32'h0000_0081);
        ev(7'h01);
        irq_chk(1'b1);
        rd("ovf flag", OFS_STATUS, 32'h0000_0001);
        irq_chk(1'b0);
        ev(7'h40);
        irq_chk(1'b1);
        wr(OFS_IRQ_CLEAR, 32'h0000_0080);
        irq_chk(1'b0);
        rd("trig kept", OFS_STATUS, 32'h0000_0080);
        $display("test irq done");

        waveform_mode_i <= 1'b1;
        ev(7'h2E);
        rd("wave flags", OFS_STATUS, 32'h0000_001C);
        clock_enabled_i <= 1'b1;
        lines_i <= line_levels_t'(4'h6);
        repeat (4) @(posedge clk_i);
        rd("wave lines", OFS_STATUS, 32'h0005_0000);
        waveform_mode_i <= 1'b0;
        rd("cap lines", OFS_STATUS, 32'h0003_0000);
        clock_enabled_i <= 1'b0;
        rd("clock off", OFS_STATUS, 32'h0002_0000);
        $display("test mirror done");
        wrap_up();
    end

endmodule : tc_status_regs_tb_top
